// *** rtl/eii_map.svh ***
`ifndef EII_MAP_SVH
`define EII_MAP_SVH
`define EII_CTRL_ADDR      6'h37
`define EII_CTRL_RESET     8'h00
`define EII_BIT_NOISE_SEL  7
`define EII_BIT_PIN_FUNC   6
`define EII_BIT_DET4_HI    5
`define EII_BIT_DET4_LO    4
`define EII_BIT_EDGE3      3
`define EII_BIT_EDGE2      2
`define EII_BIT_EDGE1      1
`define EII_FILT_SHORT     8'd4
`define EII_FILT_ONE_SHORT 8'd30
`define EII_FILT_ONE_LONG  8'd120
`define EII_FILT_MID       8'd14
`define EII_FILT_SLOW      8'd2
`endif

// *** rtl/eii_pkg.sv ***
package eii_pkg;
   typedef enum logic [1:0] {
      EII_DET_RISE,
      EII_DET_FALL,
      EII_DET_BOTH,
      EII_DET_HIGH
   } eii_det_t;
   typedef struct packed {
      logic [1:0] rst_sync;
      logic [5:0] pin_s1;
      logic [5:0] pin_s2;
      logic [5:0] filt;
      logic [5:0] filt_d;
      logic [47:0] cnt;
      logic [1:0] ls_sync;
      logic [1:0] lsc_sync;
      logic       lsc_d;
      logic [7:0] ctrl;
      logic [7:0] rdata;
      logic [5:0] ev;
      logic       l14;
      logic       l15;
      logic       l4;
      logic       trap_rst;
      logic       trap_irq;
      logic       armed4;
   } eii_state_t;
endpackage

// *** rtl/eii_top.sv ***
`timescale 1ns/1ps
`include "eii_map.svh"
module eii_top (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic [5:0] irq_pin,
   input  wire logic       low_speed_mode,
   input  wire logic       low_speed_clock,
   input  wire logic       reg_sel,
   input  wire logic       reg_wr,
   input  wire logic [5:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       latch14_source_sel,
   input  wire logic       latch15_source_sel,
   input  wire logic       serial_tx_event,
   input  wire logic       converter_done_event,
   input  wire logic       latch_clear_zero,
   input  wire logic       fetch_forbidden,
   input  wire logic       watchdog_control,
   output logic [7:0]      reg_rdata,
   output logic [5:0]      irq_set,
   output logic            latch_for_irq_zero,
   output logic            fetch_trap_irq,
   output logic            trap_reset,
   output logic            port0_bit0_is_port
);
   eii_pkg::eii_state_t s;
   eii_pkg::eii_state_t next_s;
   logic                rst_q_n;
   assign rst_q_n = s.rst_sync[1];
   function automatic logic [7:0] eii_len(input logic [2:0] i, input logic slow, input logic nsel);
      logic [7:0] v;
      v = `EII_FILT_MID;
      if (i == 3'd0 || i == 3'd5) v = `EII_FILT_SHORT;
      if (i == 3'd1) v = nsel ? `EII_FILT_ONE_SHORT : `EII_FILT_ONE_LONG;
      if (slow) v = `EII_FILT_SLOW;
      return v;
   endfunction
   always_comb begin
      logic       rise;
      logic       fall;
      logic       hit;
      logic       lsc_edge;
      logic [7:0] len;
      eii_pkg::eii_det_t det;
      rise = 1'b0;
      fall = 1'b0;
      hit = 1'b0;
      lsc_edge = 1'b0;
      len = 8'h00;
      det = eii_pkg::eii_det_t'(s.ctrl[`EII_BIT_DET4_HI:`EII_BIT_DET4_LO]);
      next_s = s;
      next_s.rst_sync = {s.rst_sync[0], 1'b1};
      next_s.pin_s1 = irq_pin;
      next_s.pin_s2 = s.pin_s1;
      next_s.ls_sync = {s.ls_sync[0], low_speed_mode};
      next_s.lsc_sync = {s.lsc_sync[0], low_speed_clock};
      next_s.lsc_d = s.lsc_sync[1];
      lsc_edge = s.lsc_sync[1] & ~s.lsc_d;
      next_s.filt_d = s.filt;
      for (int i = 0; i < 6; i++) begin
         len = eii_len(3'(i), s.ls_sync[1], s.ctrl[`EII_BIT_NOISE_SEL]);
         if (s.pin_s2[i] == s.filt[i]) begin
            next_s.cnt[i*8 +: 8] = 8'h00;
         end else if (!s.ls_sync[1] || lsc_edge) begin
            if (s.cnt[i*8 +: 8] + 8'h01 >= len) begin
               next_s.filt[i] = s.pin_s2[i];
               next_s.cnt[i*8 +: 8] = 8'h00;
            end else begin
               next_s.cnt[i*8 +: 8] = s.cnt[i*8 +: 8] + 8'h01;
            end
         end
      end
      for (int i = 0; i < 6; i++) begin
         rise = s.filt[i] & ~s.filt_d[i];
         fall = ~s.filt[i] & s.filt_d[i];
         unique case (i)
            0, 5: hit = fall;
            1: hit = s.ctrl[`EII_BIT_EDGE1] ? fall : rise;
            2: hit = s.ctrl[`EII_BIT_EDGE2] ? fall : rise;
            3: hit = s.ctrl[`EII_BIT_EDGE3] ? fall : rise;
            default: begin
               unique case (det)
                  eii_pkg::EII_DET_RISE: hit = rise;
                  eii_pkg::EII_DET_FALL: hit = fall;
                  eii_pkg::EII_DET_BOTH: hit = rise | fall;
                  eii_pkg::EII_DET_HIGH: hit = s.filt[i] & s.armed4;
               endcase
            end
         endcase
         next_s.ev[i] = hit;
      end
      if (s.filt[4] & ~s.filt_d[4]) next_s.armed4 = 1'b1;
      // Shared-pin output glitches are blocked: ev[0] is masked off unless ctrl bit 6 (EII_BIT_PIN_FUNC) selects the interrupt function.
      next_s.ev[0] = next_s.ev[0] & s.ctrl[`EII_BIT_PIN_FUNC];
      next_s.l14 = latch14_source_sel ? serial_tx_event : next_s.ev[4];
      next_s.l15 = latch15_source_sel ? converter_done_event : next_s.ev[5];
      if (s.ev[0]) next_s.l4 = 1'b1;
      else if (latch_clear_zero) next_s.l4 = 1'b0;
      next_s.trap_rst = fetch_forbidden & watchdog_control;
      next_s.trap_irq = fetch_forbidden & ~watchdog_control;
      if (reg_sel && reg_wr && reg_addr == `EII_CTRL_ADDR) begin
         next_s.ctrl = {reg_wdata[7:1], 1'b0};
      end
      next_s.rdata = (reg_sel && reg_addr == `EII_CTRL_ADDR) ? s.ctrl : 8'h00;
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
         s.ctrl <= `EII_CTRL_RESET;
      end else if (!rst_q_n) begin
         s <= '0;
         s.rst_sync <= next_s.rst_sync;
         s.pin_s1 <= next_s.pin_s1;
         s.pin_s2 <= next_s.pin_s2;
         s.filt <= next_s.pin_s2;
         s.filt_d <= next_s.pin_s2;
      end else begin
         s <= next_s;
      end
   end
   assign reg_rdata = s.rdata;
   assign irq_set = {s.l15, s.l14, s.ev[3:0]};
   assign latch_for_irq_zero = s.l4;
   assign fetch_trap_irq = s.trap_irq;
   assign trap_reset = s.trap_rst;
   assign port0_bit0_is_port = ~s.ctrl[`EII_BIT_PIN_FUNC];
endmodule

// *** sim/eii_src_model.sv ***
`timescale 1ns/1ps
module eii_src_model (
   input  wire logic       mclk,
   input  wire logic [5:0] want,
   output logic [5:0]      pin
);
   // Pins change just after an edge, unrelated to the filters.
   always_ff @(posedge mclk) pin <= want;
endmodule

// *** sim/eii_props.sv ***
`timescale 1ns/1ps
module eii_props (
   input wire logic       mclk,
   input wire logic       rst_n,
   input wire logic       reg_sel,
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_rdata,
   input wire logic [5:0] irq_set,
   input wire logic       latch_for_irq_zero,
   input wire logic       latch_clear_zero,
   input wire logic       fetch_forbidden,
   input wire logic       watchdog_control,
   input wire logic       fetch_trap_irq,
   input wire logic       trap_reset,
   input wire logic       port0_bit0_is_port
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_trap(w);
      fetch_forbidden && watchdog_control == w;
   endsequence
   a_trap_to_reset: assert property (s_trap(1'b1) |=> trap_reset && !fetch_trap_irq) else $error("trap reset");
   a_trap_to_irq: assert property (s_trap(1'b0) |=> fetch_trap_irq && !trap_reset) else $error("trap irq");
   a_no_trap: assert property (!fetch_forbidden |=> !fetch_trap_irq && !trap_reset) else $error("trap idle");
   a_port_blocks: assert property (port0_bit0_is_port[*2] |-> !irq_set[0]) else $error("port set");
   a_latch_sets: assert property (irq_set[0] |=> latch_for_irq_zero) else $error("latch set");
   a_latch_holds: assert property (latch_for_irq_zero && !latch_clear_zero |=> latch_for_irq_zero) else $error("hold");
   a_single_pulse: assert property (irq_set[1] |=> !irq_set[1]) else $error("pulse");
   a_rdata_unmapped: assert property (reg_sel && reg_addr != 6'h37 |=> reg_rdata == 8'h00) else $error("rdata");
   a_reset_port: assert property ($rose(rst_n) |-> port0_bit0_is_port) else $error("port reset");
endmodule
bind eii_top eii_props chk (.*);

// *** sim/external_interrupt_inputs_test.sv ***
`timescale 1ns/1ps
module external_interrupt_inputs_test;
   logic       mclk, rst_n, sel, wr, ff, wdc, clr, ssel, lat, tirq, trst, isport, lsm, lsc;
   logic [5:0] want, pin, addr, set;
   logic [7:0] wd, rd;
   int         failures, n_tests;
   eii_src_model src (.mclk(mclk), .want(want), .pin(pin));
   eii_top dut (.mclk(mclk), .rst_n(rst_n), .irq_pin(pin), .low_speed_mode(lsm), .low_speed_clock(lsc),
      .reg_sel(sel), .reg_wr(wr), .reg_addr(addr), .reg_wdata(wd), .latch14_source_sel(ssel),
      .latch15_source_sel(ssel), .serial_tx_event(1'b0), .converter_done_event(1'b0),
      .latch_clear_zero(clr), .fetch_forbidden(ff), .watchdog_control(wdc), .reg_rdata(rd),
      .irq_set(set), .latch_for_irq_zero(lat), .fetch_trap_irq(tirq), .trap_reset(trst),
      .port0_bit0_is_port(isport));
   initial begin
      mclk = 0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic chk(input logic c);
      n_tests++;
      if (c !== 1'b1) begin
         failures++;
         $display("CHECK FAILED %0t mismatch", $time);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask
   task automatic wreg(input logic [7:0] d);
      {sel, wr, addr, wd} = {2'b11, 6'h37, d};
      step(1);
      {sel, wr} = 2'b00;
   endtask
   task automatic rreg(input logic [5:0] a, input logic [7:0] e);
      {sel, addr} = {1'b1, a};
      step(1);
      sel = 0;
      chk(rd === e);
   endtask
   task automatic pulse(input int b, input int w, input int n);
      int hits;
      hits = 0;
      want[b] = ~want[b];
      for (int i = 0; i < 90; i++) begin
         if (i == w) want[b] = ~want[b];
         lsc = i[2];
         step(1);
         if (set[b] === 1'b1) hits++;
      end
      chk(hits == n);
   endtask
   task automatic trap(input logic w);
      {ff, wdc} = {1'b1, w};
      step(1);
      ff = 0;
      chk(trst === w && tirq === !w);
   endtask
   task automatic report_and_stop;
      $display("failures=%0d n_tests=%0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      {sel, wr, ff, wdc, clr, ssel, rst_n, lsm, lsc, addr, wd} = '0;
      want = 6'h31;
      step(6);
      rst_n = 1;
      step(4);
      chk(isport === 1'b1);
      rreg(6'h37, 8'h00);
      wreg(8'h30);
      pulse(4, 0, 0);
      wreg(8'ha0);
      pulse(4, 30, 2);
      wreg(8'h90);
      pulse(4, 30, 1);
      wreg(8'h80);
      pulse(4, 30, 1);
      pulse(1, 10, 0);
      pulse(1, 40, 1);
      pulse(2, 5, 0);
      pulse(2, 25, 1);
      pulse(3, 25, 1);
      wreg(8'h82);
      pulse(1, 40, 1);
      pulse(0, 10, 0);
      wreg(8'hc0);
      pulse(0, 1, 0);
      pulse(0, 7, 1);
      chk(lat === 1'b1 && isport === 1'b0);
      clr = 1;
      step(1);
      clr = 0;
      step(1);
      chk(lat === 1'b0);
      pulse(5, 1, 0);
      pulse(5, 7, 1);
      ssel = 1;
      pulse(5, 7, 0);
      lsm = 1;
      step(4);
      pulse(2, 4, 0);
      pulse(2, 28, 1);
      lsm = 0;
      step(4);
      wreg(8'hff);
      rreg(6'h37, 8'hfe);
      rreg(6'h36, 8'h00);
      trap(1'b1);
      trap(1'b0);
      report_and_stop();
   end
endmodule
